// File: rtl/rcb_map.svh
`ifndef RCB_MAP_SVH
`define RCB_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define RCB_IDX_BROWNOUT_CONTROL  11'h049
`define RCB_IDX_FLAGS_A           11'h4f0
`define RCB_IDX_FLAGS_B           11'h4f1

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RCB_BIT_SW_BROWNOUT_ENABLE  7
`define RCB_BIT_BROWNOUT_READY      0
`define RCB_BIT_STACK_OVERFLOW      7
`define RCB_BIT_STACK_UNDERFLOW     6
`define RCB_BIT_WINDOW_VIOLATION    5
`define RCB_BIT_WATCHDOG_TIMEOUT    4
`define RCB_BIT_EXT_RESET_PIN       3
`define RCB_BIT_RESET_INSTR         2
`define RCB_BIT_POWERON             1
`define RCB_BIT_BROWNOUT            0
`define RCB_BIT_IO2_SUPPLY_POWERON  3
`define RCB_BIT_CORE_REG_FAULT      2
`define RCB_BIT_MEMORY_VIOLATION    1
`define RCB_BIT_CONFIG_LATCH        0

// ----------------------------------------------------------------------------
// Reset values after power-on or brown-out
// ----------------------------------------------------------------------------
`define RCB_RST_SW_BROWNOUT_ENABLE  1'b1
`define RCB_RST_FLAGS_A             8'h3d
`define RCB_RST_FLAGS_B             4'h4

// ----------------------------------------------------------------------------
// Event vector positions
// ----------------------------------------------------------------------------
`define RCB_EV_STACK_OVERFLOW    0
`define RCB_EV_STACK_UNDERFLOW   1
`define RCB_EV_WINDOW_VIOLATION  2
`define RCB_EV_WATCHDOG_TIMEOUT  3
`define RCB_EV_EXT_RESET_PIN     4
`define RCB_EV_RESET_INSTR       5
`define RCB_EV_IO2_POWERON       6
`define RCB_EV_CORE_REG_FAULT    7
`define RCB_EV_MEMORY_VIOLATION  8
`define RCB_EV_CONFIG_LATCH      9
`define RCB_EV_BROWNOUT_READY    10
`define RCB_EV_BROWNOUT_CAUSE    11
`define RCB_EV_COUNT             12

`endif

// File: rtl/rcb_pkg.sv
package rcb_pkg;
  typedef logic [7:0] rcb_byte_t;

  typedef enum logic [1:0] {
    RCB_BO_OFF  = 2'b00,
    RCB_BO_SW   = 2'b01,
    RCB_BO_AWK  = 2'b10,
    RCB_BO_ON   = 2'b11
  } rcb_bo_mode_t;
endpackage

// File: rtl/rcb_sync_if.sv
`timescale 1ns/1ns
`default_nettype none

interface rcb_sync_if #(
  parameter int W = 12
);
  logic [W-1:0] raw;
  logic [W-1:0] synced;

  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface

`default_nettype wire

// File: rtl/rcb_sync.sv
`timescale 1ns/1ns
`default_nettype none

module rcb_sync #(
  parameter int W = 12
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic ce_i,
  rcb_sync_if.dst   sif
);

  // ----------------------------------------------------------------------------
  // Two-stage synchroniser per bit
  // ----------------------------------------------------------------------------
  for (genvar g = 0; g < W; g++) begin : g_bit
    logic meta_ff;
    logic sync_ff;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        meta_ff <= 1'b0;
        sync_ff <= 1'b0;
      end else if (ce_i) begin
        meta_ff <= sif.raw[g];
        sync_ff <= meta_ff;
      end
    end

    assign sif.synced[g] = sync_ff;
  end

endmodule // rcb_sync

`default_nettype wire

// File: rtl/rcb_regs.sv
// Notes on behaviour
// - Software enable steers detector only in mode 01
// - Software enable bit 7, set by reset
// - Ready bit shows armed detector only
// - Stack overflow sets bit 7
// - Stack underflow sets bit 6, firmware clears
// - Window violation clears bit 5
// - Watchdog timeout clears bit 4
// - External pin reset clears bit 3
// - Reset instruction clears bit 2
// - Power-on clears bit 1
// - Brown-out clears bit 0
// - Second supply power-on clears bit 3
// - Regulator fault clears bit 2
// - Memory violation clears bit 1
// - Config latch flag is active high
// - Registers decode at 0x49, 0x4f0, 0x4f1
// - Event touches only its own flag, except brown-out strap, which also sets bit 1
// - Firmware writes never start a reset
// - Stack flags need stack reset enable
`timescale 1ns/1ns
`default_nettype none
`include "rcb_map.svh"

module rcb_regs
  import rcb_pkg::*;
#(
  parameter int ADR_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             ce_i,
  // Wishbone classic slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Configuration, same clock
  input  wire logic [1:0]       brownout_cfg_mode_i,
  input  wire logic             stack_reset_enable_i,
  // Reset-cause levels from the reset generators, asynchronous
  input  wire logic             stack_overflow_evt_i,
  input  wire logic             stack_underflow_evt_i,
  input  wire logic             window_violation_evt_i,
  input  wire logic             watchdog_timeout_evt_i,
  input  wire logic             ext_reset_pin_evt_i,
  input  wire logic             reset_instr_evt_i,
  input  wire logic             io2_poweron_evt_i,
  input  wire logic             core_reg_fault_evt_i,
  input  wire logic             memory_violation_evt_i,
  input  wire logic             config_latch_evt_i,
  input  wire logic             brownout_ready_i,
  input  wire logic             brownout_cause_i,
  // Detector control
  output logic                  brownout_detector_en_o
);

  // ----------------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------------
  rcb_sync_if #(.W(`RCB_EV_COUNT)) sif ();

  assign sif.raw = {brownout_cause_i, brownout_ready_i, config_latch_evt_i,
                    memory_violation_evt_i, core_reg_fault_evt_i, io2_poweron_evt_i,
                    reset_instr_evt_i, ext_reset_pin_evt_i, watchdog_timeout_evt_i,
                    window_violation_evt_i, stack_underflow_evt_i, stack_overflow_evt_i};

  rcb_sync #(.W(`RCB_EV_COUNT)) u_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .ce_i     (ce_i),
    .sif      (sif)
  );

  // ----------------------------------------------------------------------------
  // Event edges
  // ----------------------------------------------------------------------------
  logic [`RCB_EV_COUNT-1:0] sync_d_ff;
  logic [`RCB_EV_COUNT-1:0] ev;
  logic [2:0]               first_ff;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_d_ff <= '0;
    end else if (ce_i) begin
      sync_d_ff <= sif.synced;
    end
  end

  // Cause caught on its rising edge, even with the core still in reset
  assign ev = sif.synced & ~sync_d_ff;

  // Strap window spans the synchroniser refill after own reset release
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      first_ff <= 3'b111;
    end else if (ce_i) begin
      first_ff <= {1'b0, first_ff[2:1]};
    end
  end

  // ----------------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------------
  logic [ADR_W-3:0] idx;
  logic             req;
  logic             wr_go;
  logic             sel_bo;
  logic             sel_a;
  logic             sel_b;

  assign idx    = wb_adr_i[ADR_W-1:2];
  assign req    = wb_cyc_i & wb_stb_i;
  // Write lands on the edge that the master sees ack
  assign wr_go  = req & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign sel_bo = (idx == (ADR_W-2)'(`RCB_IDX_BROWNOUT_CONTROL));
  assign sel_a  = (idx == (ADR_W-2)'(`RCB_IDX_FLAGS_A));
  assign sel_b  = (idx == (ADR_W-2)'(`RCB_IDX_FLAGS_B));

  // ----------------------------------------------------------------------------
  // Brown-out control
  // ----------------------------------------------------------------------------
  logic         sw_brownout_enable_ff;
  logic         detector_en;
  logic         brownout_circuit_ready;
  rcb_bo_mode_t mode;

  assign mode = rcb_bo_mode_t'(brownout_cfg_mode_i);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sw_brownout_enable_ff <= `RCB_RST_SW_BROWNOUT_ENABLE;
    end else if (ce_i && wr_go && sel_bo) begin
      sw_brownout_enable_ff <= wb_dat_i[`RCB_BIT_SW_BROWNOUT_ENABLE];
    end
  end

  always_comb begin
    unique case (mode)
      RCB_BO_OFF: detector_en = 1'b0;
      RCB_BO_SW:  detector_en = sw_brownout_enable_ff;
      RCB_BO_AWK: detector_en = 1'b1;
      RCB_BO_ON:  detector_en = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      brownout_detector_en_o <= 1'b0;
    end else if (ce_i) begin
      brownout_detector_en_o <= detector_en;
    end
  end

  assign brownout_circuit_ready = brownout_detector_en_o
                                  & sif.synced[`RCB_EV_BROWNOUT_READY];

  // ----------------------------------------------------------------------------
  // Reset-cause flags
  // ----------------------------------------------------------------------------
  rcb_byte_t  flags_a_ff;
  logic [3:0] flags_b_ff;
  rcb_byte_t  nxt_flags_a;
  logic [3:0] nxt_flags_b;

  always_comb begin
    nxt_flags_a = flags_a_ff;
    nxt_flags_b = flags_b_ff;
    // Plain store, nothing else is triggered by a write
    if (wr_go && sel_a) begin
      nxt_flags_a = wb_dat_i[7:0];
    end
    if (wr_go && sel_b) begin
      nxt_flags_b = wb_dat_i[3:0];
    end
    // Hardware events after the write, so a coincident event wins
    if (stack_reset_enable_i) begin
      if (ev[`RCB_EV_STACK_OVERFLOW]) begin
        nxt_flags_a[`RCB_BIT_STACK_OVERFLOW] = 1'b1;
      end
      if (ev[`RCB_EV_STACK_UNDERFLOW]) begin
        nxt_flags_a[`RCB_BIT_STACK_UNDERFLOW] = 1'b1;
      end
    end
    if (ev[`RCB_EV_WINDOW_VIOLATION]) begin
      nxt_flags_a[`RCB_BIT_WINDOW_VIOLATION] = 1'b0;
    end
    if (ev[`RCB_EV_WATCHDOG_TIMEOUT]) begin
      nxt_flags_a[`RCB_BIT_WATCHDOG_TIMEOUT] = 1'b0;
    end
    if (ev[`RCB_EV_EXT_RESET_PIN]) begin
      nxt_flags_a[`RCB_BIT_EXT_RESET_PIN] = 1'b0;
    end
    if (ev[`RCB_EV_RESET_INSTR]) begin
      nxt_flags_a[`RCB_BIT_RESET_INSTR] = 1'b0;
    end
    // Brown-out strap read once after own reset release
    if (first_ff[0] && sif.synced[`RCB_EV_BROWNOUT_CAUSE]) begin
      nxt_flags_a[`RCB_BIT_BROWNOUT] = 1'b0;
      nxt_flags_a[`RCB_BIT_POWERON]  = 1'b1;
    end
    if (ev[`RCB_EV_IO2_POWERON]) begin
      nxt_flags_b[`RCB_BIT_IO2_SUPPLY_POWERON] = 1'b0;
    end
    if (ev[`RCB_EV_CORE_REG_FAULT]) begin
      nxt_flags_b[`RCB_BIT_CORE_REG_FAULT] = 1'b0;
    end
    if (ev[`RCB_EV_MEMORY_VIOLATION]) begin
      nxt_flags_b[`RCB_BIT_MEMORY_VIOLATION] = 1'b0;
    end
    if (ev[`RCB_EV_CONFIG_LATCH]) begin
      nxt_flags_b[`RCB_BIT_CONFIG_LATCH] = 1'b1;
    end
  end

  // Reset values: power-on leaves bit 1 low, bit 0 chosen high
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags_a_ff <= `RCB_RST_FLAGS_A;
    end else if (ce_i) begin
      flags_a_ff <= nxt_flags_a;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags_b_ff <= `RCB_RST_FLAGS_B;
    end else if (ce_i) begin
      flags_b_ff <= nxt_flags_b;
    end
  end

  // ----------------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------------
  rcb_byte_t rd_byte;

  always_comb begin
    rd_byte = '0;
    if (sel_bo) begin
      rd_byte[`RCB_BIT_SW_BROWNOUT_ENABLE] = sw_brownout_enable_ff;
      rd_byte[`RCB_BIT_BROWNOUT_READY]     = brownout_circuit_ready;
    end else if (sel_a) begin
      rd_byte = flags_a_ff;
    end else if (sel_b) begin
      rd_byte = {4'h0, flags_b_ff};
    end
  end

  // Ack one cycle after the request, dropped in the next
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_dat_o <= (req && !wb_ack_o && !wb_we_i) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

endmodule // rcb_regs

`default_nettype wire

// File: tb/rcb_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none

module rcb_regs_checker #(
  parameter int ADR_W = 16
) (
  input wire logic             clk_i,
  input wire logic             arst_n_i,
  input wire logic             ce_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic [1:0]       brownout_cfg_mode_i,
  input wire logic             brownout_detector_en_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // --------------------------------------------------------------------------
  // Bus answer
  // --------------------------------------------------------------------------
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence

  sequence s_one_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  sequence s_ctrl_read_det_off;
    wb_ack_o && $past(wb_adr_i[ADR_W-1:2]) == 14'h049 && !$past(brownout_detector_en_o) &&
      !$past(brownout_detector_en_o, 2) && !$past(brownout_detector_en_o, 3);
  endsequence

  chk_ack_one_pulse: assert property (s_taken |=> s_one_pulse)
    else $error("ack not a single pulse one cycle after request");
  chk_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside answer");
  chk_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bytes not zero");
  chk_unmapped_reads_zero: assert property (wb_ack_o && !($past(wb_adr_i[ADR_W-1:2]) inside
    {14'h049, 14'h4f0, 14'h4f1}) |-> wb_dat_o == 32'h0)
    else $error("unmapped location read not zero");

  // --------------------------------------------------------------------------
  // Detector control
  // --------------------------------------------------------------------------
  chk_det_mode_off: assert property (ce_i && brownout_cfg_mode_i == 2'b00 |=> !brownout_detector_en_o)
    else $error("detector on while mode is off");
  chk_det_mode_on: assert property (ce_i && brownout_cfg_mode_i[1] |=> brownout_detector_en_o)
    else $error("detector off while mode forces it on");
  chk_ready_gated: assert property (s_ctrl_read_det_off |-> !wb_dat_o[0])
    else $error("ready status set while detector disabled");
endmodule // rcb_regs_checker

bind rcb_regs rcb_regs_checker #(.ADR_W(ADR_W)) u_chk (.clk_i, .arst_n_i, .ce_i, .wb_cyc_i,
  .wb_stb_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .brownout_cfg_mode_i, .brownout_detector_en_o);

`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import rcb_pkg::*;
  logic        clk_i    = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [1:0]  mode     = 2'b01;
  logic        stk_en   = 1'b0;
  logic [9:0]  evt      = 10'h000;
  logic        rdy      = 1'b1;
  logic        bo_cause = 1'b0;
  logic        det_en;
  rcb_byte_t   rd;
  int          bad_count = 0;
  int          checks    = 0;
  logic [15:0] mask [10] = '{16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0008,
                             16'h0004, 16'h0800, 16'h0400, 16'h0200, 16'h0100};

  always #10 clk_i = ~clk_i;

  rcb_regs #(.ADR_W(16)) dut (
    .clk_i, .arst_n_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .brownout_cfg_mode_i(mode), .stack_reset_enable_i(stk_en),
    .stack_overflow_evt_i(evt[0]), .stack_underflow_evt_i(evt[1]),
    .window_violation_evt_i(evt[2]), .watchdog_timeout_evt_i(evt[3]),
    .ext_reset_pin_evt_i(evt[4]), .reset_instr_evt_i(evt[5]),
    .io2_poweron_evt_i(evt[6]), .core_reg_fault_evt_i(evt[7]),
    .memory_violation_evt_i(evt[8]), .config_latch_evt_i(evt[9]),
    .brownout_ready_i(rdy), .brownout_cause_i(bo_cause), .brownout_detector_en_o(det_en)
  );

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [15:0] a, input rcb_byte_t d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    @(negedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      n++;
      @(negedge clk_i);
    end
    if (n >= 50) bad_count++;
    rd = wb_dat_o[7:0];
    @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_flags(output logic [15:0] f);
    wb(1'b0, 16'h13c4, 8'h00);
    f[15:8] = rd;
    wb(1'b0, 16'h13c0, 8'h00);
    f[7:0] = rd;
  endtask

  task automatic set_inactive;
    wb(1'b1, 16'h13c0, 8'h3f);
    wb(1'b1, 16'h13c4, 8'h0e);
  endtask

  task automatic pulse(input int i);
    evt[i] <= 1'b1;
    repeat (4) @(posedge clk_i);
    evt <= 10'h000;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic do_reset(input logic cause);
    bo_cause <= cause;
    arst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    logic [15:0] f;
    logic        x;
    do_reset(1'b0);
    wb(1'b0, 16'h0124, 8'h00);
    chk("ctrl_reset", {8'h0, rd}, 16'h0081);
    rd_flags(f);
    chk("flags_reset", f, 16'h043d);
    wb(1'b1, 16'h0128, 8'hff);
    wb(1'b0, 16'h0128, 8'h00);
    chk("unmapped", {8'h0, rd}, 16'h0000);
    wb(1'b0, 16'h13c8, 8'h00);
    chk("neighbour", {8'h0, rd}, 16'h0000);
    rd_flags(f);
    chk("flags_kept", f, 16'h043d);
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        mode <= m[1:0];
        wb(1'b1, 16'h0124, {s[0], 7'h00});
        repeat (3) @(posedge clk_i);
        x = (m == 1) ? s[0] : m[1];
        chk("det_en", {15'h0, det_en}, {15'h0, x});
        wb(1'b0, 16'h0124, 8'h00);
        chk("ctrl", {8'h0, rd}, {8'h0, s[0], 6'h00, x});
      end
    end
    rdy <= 1'b0;
    repeat (3) @(posedge clk_i);
    wb(1'b0, 16'h0124, 8'h00);
    chk("ctrl_not_ready", {8'h0, rd}, 16'h0080);
    rdy <= 1'b1;
    wb(1'b1, 16'h13c0, 8'hc0);
    rd_flags(f);
    chk("fw_active", f, 16'h04c0);
    set_inactive;
    pulse(0);
    rd_flags(f);
    chk("stack_gated", f, 16'h0e3f);
    stk_en <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      set_inactive;
      pulse(i);
      rd_flags(f);
      chk("event_flags", f, 16'h0e3f ^ mask[i]);
    end
    wb(1'b1, 16'h0124, 8'h00);
    do_reset(1'b1);
    rd_flags(f);
    chk("brownout_reset", f, 16'h043e);
    wb(1'b0, 16'h0124, 8'h00);
    chk("ctrl_after_bor", {8'h0, rd}, 16'h0081);
    end_sim;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    end_sim;
  end
endmodule // testbench

`default_nettype wire
